// ==== list_seq_map.svh ====
`ifndef LIST_SEQ_MAP_SVH
`define LIST_SEQ_MAP_SVH
`define WAIT_TRIG_BIT 5
`define OPER_COND_W 16
`define INIT_SETPOINT 16'h0000
`define LIST_DEPTH 20
`endif

// ==== list_seq_pkg.sv ====
package list_seq_pkg;
    typedef enum logic {src_bus_type_v, src_backplane_type_v} trig_src_type;
    typedef struct packed {
        logic list_mode;
        trig_src_type trig_src;
        logic master_out;
        logic trig_out_enable;
    } config_type;
    typedef struct packed {
        logic initiate;
        logic bus_trigger;
        logic immediate_trigger;
    } command_type;
endpackage

// ==== trigger_paced_list_sequencer.sv ====
// What this block does
// - Waiting-for-trigger shown on status bit five
// - Immediate trigger accepted whenever armed, any source
// - List mode takes setpoint from list
// - Hold initial 0 V before first trigger
// - Bus trigger advances list pointer, applies point
// - Master pulses backplane line with bus step
// - Backplane trigger steps list once synchronised and edge-detected
// - Respond only to the selected source
// - Exactly one list point per trigger
// - Drive backplane line only when enabled
// - Ignore triggers until initiate arms
`timescale 1ns/10ps
`include "list_seq_map.svh"
module trigger_paced_list_sequencer #(
    parameter int DEPTH = `LIST_DEPTH,
    parameter int VW = 16
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire list_seq_pkg::config_type cfg,
    input wire list_seq_pkg::command_type cmd,
    input wire logic [VW-1:0] fixed_setpoint,
    input wire logic list_wr,
    input wire logic [$clog2(DEPTH)-1:0] list_wr_addr,
    input wire logic [VW-1:0] list_wr_data,
    input wire logic [$clog2(DEPTH)-1:0] list_count,
    input wire logic backplane_trigger_line_in,
    output logic backplane_trigger_line_out,
    output logic backplane_trigger_line_oe,
    output logic [VW-1:0] setpoint,
    output logic [`OPER_COND_W-1:0] oper_cond,
    output logic step_done
);
    import list_seq_pkg::*;
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || VW < 1 || VW > 16) begin
            $error("Unsupported parameters");
        end
    end

    logic [VW-1:0] list_mem [DEPTH];
    logic bp_s1_r;
    logic bp_s2_r;
    logic bp_s3_r;
    logic armed_r;
    logic started_r;
    logic done_r;
    logic [AW-1:0] ptr_r;
    logic [VW-1:0] point_r;
    logic bp_edge;
    logic bus_ok;
    logic bp_ok;
    logic trig;
    logic end_pt;
    logic step_now;
    logic echo_nxt;
    logic [`OPER_COND_W-1:0] oper_cond_nxt;

    // Final point: the programmed last one, or the top of the store
    function automatic logic is_final_point(
        input logic [AW-1:0] ptr,
        input logic [AW-1:0] last
    );
        return (ptr >= last) || (ptr == AW'(DEPTH - 1));
    endfunction

    // Source match, shared by the bus and the backplane paths
    function automatic logic source_selected(
        input trig_src_type sel,
        input trig_src_type cand
    );
        return sel == cand;
    endfunction

    always_ff @(posedge core_clk) begin
        if (list_wr) begin
            list_mem[list_wr_addr] <= list_wr_data;
        end
    end

    // Line is asynchronous to us; sync before edge detect
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bp_s1_r <= 1'b0;
            bp_s2_r <= 1'b0;
            bp_s3_r <= 1'b0;
        end else begin
            bp_s1_r <= backplane_trigger_line_in;
            bp_s2_r <= bp_s1_r;
            bp_s3_r <= bp_s2_r;
        end
    end

    assign bp_edge = bp_s2_r & ~bp_s3_r;
    assign bus_ok = cmd.bus_trigger && source_selected(cfg.trig_src, src_bus_type_v);
    assign bp_ok = bp_edge && source_selected(cfg.trig_src, src_backplane_type_v);
    assign trig = armed_r && (bus_ok || bp_ok || cmd.immediate_trigger);
    assign end_pt = is_final_point(ptr_r, list_count);
    assign step_now = trig && !done_r;
    assign echo_nxt = cfg.master_out && cfg.trig_out_enable && armed_r && bus_ok && !done_r;

    // Arm on initiate; the final point disarms, also for an oversized count
    always_ff @(posedge core_clk) begin
        if (srst) begin
            armed_r <= 1'b0;
        end else if (cmd.initiate) begin
            armed_r <= 1'b1;
        end else if (trig && end_pt) begin
            armed_r <= 1'b0;
        end
    end

    // Pointer parks on the final point rather than wrapping
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ptr_r <= '0;
        end else if (cmd.initiate) begin
            ptr_r <= '0;
        end else if (step_now && !end_pt) begin
            ptr_r <= ptr_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            done_r <= 1'b0;
        end else if (cmd.initiate) begin
            done_r <= 1'b0;
        end else if (step_now && end_pt) begin
            done_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            started_r <= 1'b0;
        end else if (cmd.initiate) begin
            started_r <= 1'b0;
        end else if (step_now) begin
            started_r <= 1'b1;
        end
    end

    // Point is fetched one cycle ahead of the setpoint register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            point_r <= '0;
        end else if (step_now) begin
            point_r <= list_mem[ptr_r];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            setpoint <= VW'(`INIT_SETPOINT);
        end else if (!cfg.list_mode) begin
            setpoint <= fixed_setpoint;
        end else if (!started_r) begin
            setpoint <= VW'(`INIT_SETPOINT);
        end else begin
            setpoint <= point_r;
        end
    end

    // Only the waiting bit is live; every other condition bit reads zero
    for (genvar b = 0; b < `OPER_COND_W; b++) begin : g_cond
        if (b == `WAIT_TRIG_BIT) begin : g_wait
            assign oper_cond_nxt[b] = armed_r && !done_r;
        end else begin : g_zero
            assign oper_cond_nxt[b] = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            oper_cond <= '0;
        end else begin
            oper_cond <= oper_cond_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            step_done <= 1'b0;
        end else begin
            step_done <= step_now;
        end
    end

    // Master echoes accepted bus steps onto the shared line
    always_ff @(posedge core_clk) begin
        if (srst) begin
            backplane_trigger_line_out <= 1'b0;
        end else begin
            backplane_trigger_line_out <= echo_nxt;
        end
    end

    // Enable follows the setting even when idle; line then sits low
    always_ff @(posedge core_clk) begin
        if (srst) begin
            backplane_trigger_line_oe <= 1'b0;
        end else begin
            backplane_trigger_line_oe <= cfg.trig_out_enable;
        end
    end
endmodule

// ==== list_seq_peer.sv ====
`timescale 1ns/10ps
module list_seq_peer (input wire logic core_clk, fire, output logic line);
    logic [2:0] sh = 3'h0;
    // Three cycles high so a two-flop synchroniser cannot miss it
    always @(posedge core_clk) sh <= {sh[1:0], fire};
    assign line = |sh;
endmodule

// ==== list_seq_chk.sv ====
`timescale 1ns/10ps
module list_seq_chk import list_seq_pkg::*; (input wire logic core_clk, srst, step_done,
    backplane_trigger_line_out, backplane_trigger_line_oe, input wire config_type cfg,
    input wire command_type cmd, input wire logic [15:0] setpoint, oper_cond);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire r = oper_cond[5] & !step_done;
    property p_a; cmd.initiate |-> ##2 oper_cond[5]; endproperty
    a_a: assert property (p_a) else $error("arm");
    property p_i; cmd.immediate_trigger && r |=> step_done; endproperty
    a_i: assert property (p_i) else $error("imm");
    property p_b; cmd.bus_trigger && !cfg.trig_src && r |=> step_done; endproperty
    a_b: assert property (p_b) else $error("bus");
    property p_s; step_done |-> $past(cmd.immediate_trigger | cmd.bus_trigger | cfg.trig_src); endproperty
    a_s: assert property (p_s) else $error("src");
    property p_m; backplane_trigger_line_out == (step_done && $past(cmd.bus_trigger & cfg.master_out
        & cfg.trig_out_enable & !cfg.trig_src)); endproperty
    a_m: assert property (p_m) else $error("mst");
    property p_o; !$past(srst) |-> backplane_trigger_line_oe == $past(cfg.trig_out_enable); endproperty
    a_o: assert property (p_o) else $error("oe");
    property p_z; cmd.initiate && cfg.list_mode |-> ##2 setpoint == 16'h0; endproperty
    a_z: assert property (p_z) else $error("zero");
    property p_e; !oper_cond[5] && !cmd.initiate && !$past(cmd.initiate) |=> !step_done; endproperty
    a_e: assert property (p_e) else $error("end");
    c_s: cover property (step_done);
    c_m: cover property (backplane_trigger_line_out);
    c_e: cover property ($fell(oper_cond[5]));
endmodule

// ==== tb_trigger_paced_list_sequencer.sv ====
`timescale 1ns/10ps
module tb_trigger_paced_list_sequencer;
    import list_seq_pkg::*;
    logic core_clk = 0, srst = 1, list_wr = 0, fire = 0, line, step_done;
    logic backplane_trigger_line_out, backplane_trigger_line_oe;
    config_type cfg = '0;
    command_type cmd = '0;
    logic [1:0] list_wr_addr = 2'h0, list_count = 2'h3;
    logic [15:0] fixed_setpoint = 16'h0, list_wr_data = 16'h0, setpoint, oper_cond, lst[4];
    logic [31:0] s = 32'hF18AF9AD;
    int err_total = 0, num_checks = 0, cyc = 0, ptr = 0;
    wire backplane_trigger_line_in = line | backplane_trigger_line_oe & backplane_trigger_line_out;
    trigger_paced_list_sequencer #(.DEPTH(4)) i_dut (.*);
    list_seq_peer i_peer (.*);
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc > 2000) begin err_total++; stop_test(); end
    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(string n, logic [15:0] g, e);
        num_checks++;
        if (g !== e) $display("ERROR %s exp %h got %h", n, e, g);
        err_total += g !== e;
    endtask
    // Eight idle cycles cover the backplane synchroniser as well
    task automatic step(command_type c, logic b, t);
        @(posedge core_clk) {cmd, fire} <= {c, b};
        @(posedge core_clk) {cmd, fire} <= 4'h0;
        #1 if (!b) begin
            chk("step_done", step_done, 16'(t && ptr < 4));
            chk("trig_out", backplane_trigger_line_out, 16'(cfg.master_out && cfg.trig_out_enable && c[1] && t && ptr < 4));
        end
        repeat (8) @(posedge core_clk);
        #1 ptr += t && ptr < 4;
        chk("setpoint", setpoint, ptr ? lst[ptr-1] : 16'h0);
    endtask
    task automatic arm(config_type c);
        @(posedge core_clk) cfg <= c;
        ptr = 0;
        step(3'h4, 0, 0);
        chk("status", oper_cond, 16'h0020);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 0;
        for (int i = 0; i < 4; i++) begin
            s = lfsr(s);
            lst[i] = s[15:0];
            @(posedge core_clk) {list_wr, list_wr_addr, list_wr_data} <= {1'b1, i[1:0], s[15:0]};
        end
        @(posedge core_clk) list_wr <= 0;
        arm('{1, src_bus_type_v, 1, 1});
        repeat (5) step(3'h2, 0, 1);
        chk("status", oper_cond, 16'h0000);
        arm('{1, src_backplane_type_v, 0, 0});
        step(3'h2, 0, 0);
        step(3'h0, 1, 1);
        step(3'h1, 0, 1);
        @(posedge core_clk) {cfg.list_mode, fixed_setpoint} <= {1'b0, s[31:16]};
        repeat (3) @(posedge core_clk);
        #1 chk("fixed", setpoint, s[31:16]);
        stop_test();
    end
endmodule
bind trigger_paced_list_sequencer list_seq_chk i_chk (.*);
